// ### design/conv_clock_div.sv
`include "touch_adc_regs.svh"

module conv_clock_div
    import touch_adc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic restart,
    input wire logic [1:0] conv_clock_select,
    output logic tick
);

    // periods round up: the core clock cannot reach 8 mhz exactly
    localparam logic [4:0] PER_8M = 5'(`CYC_UP(`CONV_T_8M_NS));
    localparam logic [4:0] PER_4M = 5'(`CYC_UP(`CONV_T_4M_NS));
    localparam logic [4:0] PER_2M = 5'(`CYC_UP(`CONV_T_2M_NS));
    localparam logic [4:0] PER_1M = 5'(`CYC_UP(`CONV_T_1M_NS));

    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } div_state_s;

    div_state_s q, d;
    logic [4:0] period;

    // rate table for the conversion clock field
    always_comb
    begin
        case (conv_clock_select)
            2'h0: period = PER_8M;
            2'h1: period = PER_4M;
            2'h2: period = PER_2M;
            default: period = PER_1M;
        endcase
    end

    // restart aligns the first tick to the conversion start
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        if (restart)
        begin
            d.cnt = 5'h0;
        end
        else if (q.cnt >= period - 5'h1)
        begin
            d.cnt = 5'h0;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 5'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

endmodule : conv_clock_div

// ### design/settle_timer.sv
module settle_timer
    import touch_adc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [21:0] count,
    output logic done
);

    typedef struct packed {
        logic run;
        logic [21:0] cnt;
        logic done;
    } timer_state_s;

    timer_state_s q, d;

    // a zero count still costs one cycle so done is always a later pulse
    always_comb
    begin
        d = q;
        d.done = 1'b0;
        if (load)
        begin
            d.run = 1'b1;
            d.cnt = count;
        end
        else if (q.run)
        begin
            if (q.cnt == 22'h0)
            begin
                d.run = 1'b0;
                d.done = 1'b1;
            end
            else
            begin
                d.cnt = q.cnt - 22'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= d;
    end

    assign done = q.done;

endmodule : settle_timer

// ### design/touch_adc_ctrl.sv
// Overview of operation
// - code zero converts nothing, reset value
// - code one scans x,y until pen lift/stop
// - code two scans x,y,p1,p2 continuously likewise
// - codes three-five: x only, y only, pressures
// - codes six, seven convert battery one/two
// - codes eight, nine convert aux one/two
// - code ten single-ended temperature into slot one
// - code twelve differential temperature into slot two
// - code eleven scans batteries then aux inputs
// - codes thirteen-fifteen only switch driver pairs
// - resolution field: 12, 8, 10, 12 bits
// - averaging field: 1, 4, 8, 16 conversions
// - busy and data-available held through averaging
// - conversion clock 8, 4, 2, 1 mhz
// - touch: driver on, settle delay, then sample
// - settle field codes 0us up to 100ms
// - control register bit zero reads zero
// - dac power-down bit, resets powered down
// - stop bit halts conversion, powers converter down
// - pen mode bit hands scans to touch sequencing
`include "touch_adc_regs.svh"

module touch_adc_ctrl
    import touch_adc_pkg::*;
#(
    parameter int unsigned SETTLE_CYC_2 = `CYC_UP(`SETTLE_T2_US * 1000),
    parameter int unsigned SETTLE_CYC_3 = `CYC_UP(`SETTLE_T3_US * 1000),
    parameter int unsigned SETTLE_CYC_4 = `CYC_UP(`SETTLE_T4_US * 1000),
    parameter int unsigned SETTLE_CYC_5 = `CYC_UP(`SETTLE_T5_US * 1000),
    parameter int unsigned SETTLE_CYC_6 = `CYC_UP(`SETTLE_T6_US * 1000),
    parameter int unsigned SETTLE_CYC_7 = `CYC_UP(`SETTLE_T7_US * 1000)
)
(
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire reg_req_s REG_REQ,
    output logic [15:0] REG_RDATA,
    input wire logic PEN_DOWN,
    output logic ADC_POWER,
    output logic ADC_START,
    output logic [3:0] ADC_CHANNEL,
    input wire logic [11:0] ADC_SAMPLE,
    output panel_drive_s PANEL_DRIVE,
    output logic DATA_AVAILABLE_OUT_N,
    output logic DAC_POWER_DOWN
);

    localparam logic [21:0] SETTLE_CYC_1 = 22'(`CYC_UP(`SETTLE_T1_US * 1000));

    typedef struct packed {
        logic [2:0] pen_sync;
        logic pen_down;
        conv_ctrl_s ctrl;
        logic dac_power_down;
        seq_state_e state;
        logic [9:0] pending;
        logic [3:0] chan;
        logic [4:0] avg_cnt;
        logic [15:0] accum;
        logic [3:0] tick_cnt;
        logic adc_start;
        logic adc_power;
        panel_drive_s drive;
        logic busy;
        logic dav_n;
        logic [15:0] rdata;
        logic settle_load;
        logic [21:0] settle_cnt;
        result_bank_t results;
    } ctrl_state_s;

    ctrl_state_s q, d;
    logic settle_done;
    logic conv_tick;

    // channels converted by each function code
    function automatic logic [9:0] func_channels(input logic [3:0] code);
        logic [9:0] m;
        m = 10'h0;
        case (code)
            4'h1: m = 10'h003;
            4'h2: m = 10'h00f;
            4'h3: m = 10'h001;
            4'h4: m = 10'h002;
            4'h5: m = 10'h00c;
            4'h6: m = 10'h010;
            4'h7: m = 10'h020;
            4'h8: m = 10'h040;
            4'h9: m = 10'h080;
            4'ha: m = 10'h100;
            4'hb: m = 10'h0f0;
            4'hc: m = 10'h200;
            default: m = 10'h0;
        endcase
        return m;
    endfunction : func_channels

    // lowest pending channel goes next
    function automatic logic [3:0] first_channel(input logic [9:0] m);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 9; i >= 0; i--)
        begin
            if (m[i])
                c = 4'(i);
        end
        return c;
    endfunction : first_channel

    // driver pair for a measured channel
    function automatic panel_drive_s channel_drive(input logic [3:0] c);
        panel_drive_s p;
        p = '0;
        if (c == `CH_X)
            p = '{x_plus: 1'b1, x_minus: 1'b1, y_plus: 1'b0, y_minus: 1'b0};
        else if (c == `CH_Y)
            p = '{x_plus: 1'b0, x_minus: 1'b0, y_plus: 1'b1, y_minus: 1'b1};
        else if (c == `CH_P1 || c == `CH_P2)
            p = '{x_plus: 1'b0, x_minus: 1'b1, y_plus: 1'b1, y_minus: 1'b0};
        return p;
    endfunction : channel_drive

    // settle delay, only the panel channels wait for it
    function automatic logic [21:0] settle_cycles(input logic [2:0] sel, input logic [3:0] c);
        logic [21:0] n;
        n = 22'h0;
        if (c <= `CH_P2)
        begin
            case (sel)
                3'h1: n = SETTLE_CYC_1;
                3'h2: n = 22'(SETTLE_CYC_2);
                3'h3: n = 22'(SETTLE_CYC_3);
                3'h4: n = 22'(SETTLE_CYC_4);
                3'h5: n = 22'(SETTLE_CYC_5);
                3'h6: n = 22'(SETTLE_CYC_6);
                3'h7: n = 22'(SETTLE_CYC_7);
                default: n = 22'h0;
            endcase
        end
        return n;
    endfunction : settle_cycles

    // ticks per conversion: one to sample plus one per bit
    function automatic logic [3:0] conv_ticks(input logic [1:0] res);
        logic [3:0] t;
        case (res)
            2'h1: t = 4'h9;
            2'h2: t = 4'hb;
            default: t = 4'hd;
        endcase
        return t;
    endfunction : conv_ticks

    function automatic logic [4:0] avg_needed(input logic [1:0] avg);
        logic [4:0] n;
        case (avg)
            2'h1: n = 5'h04;
            2'h2: n = 5'h08;
            2'h3: n = 5'h10;
            default: n = 5'h01;
        endcase
        return n;
    endfunction : avg_needed

    // divide the sum, then cut the sample to the selected resolution
    function automatic logic [11:0] scale_result(input logic [15:0] sum,
        input logic [1:0] avg, input logic [1:0] res);
        logic [15:0] mean;
        logic [11:0] r;
        case (avg)
            2'h1: mean = sum >> 2;
            2'h2: mean = sum >> 3;
            2'h3: mean = sum >> 4;
            default: mean = sum;
        endcase
        case (res)
            2'h1: r = {4'h0, mean[11:4]};
            2'h2: r = {2'h0, mean[11:2]};
            default: r = mean[11:0];
        endcase
        return r;
    endfunction : scale_result

    function automatic logic is_touch_func(input logic [3:0] code);
        return code >= 4'h1 && code <= 4'h5;
    endfunction : is_touch_func

    always_comb
    begin
        logic launch;
        logic [9:0] next_pending;
        logic [3:0] next_chan;
        launch = 1'b0;
        next_pending = 10'h0;
        next_chan = 4'h0;
        d = q;
        d.adc_start = 1'b0;
        d.settle_load = 1'b0;

        // pen pin: three stages, accepted once the last two agree
        d.pen_sync = {q.pen_sync[1:0], PEN_DOWN};
        if (q.pen_sync[1] == q.pen_sync[2])
            d.pen_down = q.pen_sync[2];

        // register reads, registered one cycle later
        if (REG_REQ.rd)
        begin
            d.rdata = 16'h0;
            if (REG_REQ.page == `CTRL_PAGE && REG_REQ.addr == `CONV_CTRL_ADDR)
            begin
                d.rdata = {q.pen_down, ~q.busy, q.ctrl.function_select,
                    q.ctrl.resolution_select, q.ctrl.average_select,
                    q.ctrl.conv_clock_select, q.ctrl.panel_settle_select, 1'b0};
            end
            else if (REG_REQ.page == `CTRL_PAGE && REG_REQ.addr == `DAC_CTRL_ADDR)
            begin
                d.rdata = {q.dac_power_down, 15'h0};
            end
            else if (REG_REQ.page == `RESULT_PAGE && REG_REQ.addr < `RESULT_COUNT)
            begin
                d.rdata = {4'h0, q.results[REG_REQ.addr[3:0]]};
                d.dav_n = 1'b1; // reading a result retires the data-available flag
            end
        end

        // register writes
        if (REG_REQ.wr && REG_REQ.page == `CTRL_PAGE && REG_REQ.addr == `DAC_CTRL_ADDR)
        begin
            d.dac_power_down = REG_REQ.wdata[`DAC_PD_BIT];
        end
        if (REG_REQ.wr && REG_REQ.page == `CTRL_PAGE && REG_REQ.addr == `CONV_CTRL_ADDR)
        begin
            d.ctrl.pen_control_mode = REG_REQ.wdata[`PEN_MODE_BIT];
            d.ctrl.function_select = REG_REQ.wdata[`FUNC_HI:`FUNC_LO];
            d.ctrl.resolution_select = REG_REQ.wdata[`RES_HI:`RES_LO];
            d.ctrl.average_select = REG_REQ.wdata[`AVG_HI:`AVG_LO];
            d.ctrl.conv_clock_select = REG_REQ.wdata[`CCLK_HI:`CCLK_LO];
            d.ctrl.panel_settle_select = REG_REQ.wdata[`SETTLE_HI:`SETTLE_LO];
            // host mode starts on the write; pen mode waits for a touch
            launch = !REG_REQ.wdata[`BUSY_STOP_BIT] && !REG_REQ.wdata[`PEN_MODE_BIT];
        end
        else if (q.state == ST_IDLE && q.ctrl.pen_control_mode && q.pen_down
            && is_touch_func(q.ctrl.function_select))
        begin
            launch = 1'b1;
        end

        // start a sequence from the just-written or stored settings
        if (launch)
        begin
            next_pending = func_channels(d.ctrl.function_select);
            next_chan = first_channel(next_pending);
            d.drive = '0;
            d.state = ST_IDLE;
            d.busy = 1'b0;
            d.adc_power = 1'b0;
            d.pending = next_pending;
            if (d.ctrl.function_select == 4'hd)
                d.drive = '{x_plus: 1'b1, x_minus: 1'b1, y_plus: 1'b0, y_minus: 1'b0};
            else if (d.ctrl.function_select == 4'he)
                d.drive = '{x_plus: 1'b0, x_minus: 1'b0, y_plus: 1'b1, y_minus: 1'b1};
            else if (d.ctrl.function_select == 4'hf)
                d.drive = '{x_plus: 1'b0, x_minus: 1'b1, y_plus: 1'b1, y_minus: 1'b0};
            else if (next_pending != 10'h0)
            begin
                d.state = ST_SETTLE;
                d.chan = next_chan;
                d.drive = channel_drive(next_chan);
                d.settle_load = 1'b1;
                d.settle_cnt = settle_cycles(d.ctrl.panel_settle_select, next_chan);
                d.busy = 1'b1;
                d.dav_n = 1'b1;
                d.adc_power = 1'b1;
            end
        end
        else
        begin
            case (q.state)
                ST_SETTLE:
                begin
                    // sampling waits for the panel to settle
                    if (settle_done)
                    begin
                        d.state = ST_CONVERT;
                        d.adc_start = 1'b1;
                        d.tick_cnt = 4'h0;
                        d.avg_cnt = 5'h0;
                        d.accum = 16'h0;
                    end
                end
                ST_CONVERT:
                begin
                    if (conv_tick)
                        d.tick_cnt = q.tick_cnt + 4'h1;
                    if (conv_tick && q.tick_cnt + 4'h1 == conv_ticks(q.ctrl.resolution_select))
                    begin
                        d.accum = q.accum + {4'h0, ADC_SAMPLE};
                        d.avg_cnt = q.avg_cnt + 5'h1;
                        d.tick_cnt = 4'h0;
                        if (q.avg_cnt + 5'h1 == avg_needed(q.ctrl.average_select))
                        begin
                            // one write per channel, only the final mean
                            d.results[q.chan] = scale_result(d.accum,
                                q.ctrl.average_select, q.ctrl.resolution_select);
                            d.pending[q.chan] = 1'b0;
                            d.state = ST_STORE;
                        end
                        else
                        begin
                            d.adc_start = 1'b1;
                        end
                    end
                end
                ST_STORE:
                begin
                    next_pending = q.pending;
                    // continuous scans reload while the pen stays down
                    if (next_pending == 10'h0 && q.pen_down
                        && (q.ctrl.function_select == 4'h1 || q.ctrl.function_select == 4'h2))
                        next_pending = func_channels(q.ctrl.function_select);
                    if (next_pending != 10'h0)
                    begin
                        next_chan = first_channel(next_pending);
                        d.pending = next_pending;
                        d.chan = next_chan;
                        d.drive = channel_drive(next_chan);
                        d.settle_load = 1'b1;
                        d.settle_cnt = settle_cycles(q.ctrl.panel_settle_select, next_chan);
                        d.state = ST_SETTLE;
                    end
                    else
                    begin
                        // busy drops only after every averaged conversion
                        d.state = ST_IDLE;
                        d.busy = 1'b0;
                        d.dav_n = 1'b0;
                        d.adc_power = 1'b0;
                        d.drive = '0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // stop wins over everything, even with the pen still down
        if (REG_REQ.wr && REG_REQ.page == `CTRL_PAGE && REG_REQ.addr == `CONV_CTRL_ADDR
            && REG_REQ.wdata[`BUSY_STOP_BIT])
        begin
            d.state = ST_IDLE;
            d.pending = 10'h0;
            d.busy = 1'b0;
            d.adc_power = 1'b0;
            d.adc_start = 1'b0;
            d.settle_load = 1'b0;
            d.drive = '0;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESET_N)
        begin
            q <= '0;
            q.ctrl.pen_control_mode <= `PEN_MODE_RST;
            q.ctrl.function_select <= `FUNC_RST;
            q.ctrl.resolution_select <= `RES_RST;
            q.ctrl.average_select <= `AVG_RST;
            q.ctrl.conv_clock_select <= `CCLK_RST;
            q.ctrl.panel_settle_select <= `SETTLE_RST;
            q.dac_power_down <= `DAC_PD_RST;
            q.state <= ST_IDLE;
            q.dav_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    settle_timer u_settle (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .load(q.settle_load),
        .count(q.settle_cnt),
        .done(settle_done)
    );

    conv_clock_div u_cclk (
        .clk(CORE_CLK),
        .reset_n(RESET_N),
        .restart(q.adc_start),
        .conv_clock_select(q.ctrl.conv_clock_select),
        .tick(conv_tick)
    );

    assign REG_RDATA = q.rdata;
    assign ADC_POWER = q.adc_power;
    assign ADC_START = q.adc_start;
    assign ADC_CHANNEL = q.chan;
    assign PANEL_DRIVE = q.drive;
    assign DATA_AVAILABLE_OUT_N = q.dav_n;
    assign DAC_POWER_DOWN = q.dac_power_down;

endmodule : touch_adc_ctrl

// ### design/touch_adc_pkg.sv
package touch_adc_pkg;

    // sequencer states, gray along idle-settle-convert-store
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_CONVERT = 2'b11,
        ST_STORE = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] page;
        logic [4:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic x_plus;
        logic x_minus;
        logic y_plus;
        logic y_minus;
    } panel_drive_s;

    typedef struct packed {
        logic pen_control_mode;
        logic [3:0] function_select;
        logic [1:0] resolution_select;
        logic [1:0] average_select;
        logic [1:0] conv_clock_select;
        logic [2:0] panel_settle_select;
    } conv_ctrl_s;

    typedef logic [9:0][11:0] result_bank_t;

endpackage : touch_adc_pkg

// ### design/touch_adc_regs.svh
`ifndef TOUCH_ADC_REGS_SVH
`define TOUCH_ADC_REGS_SVH

// register map: page and word address
`define RESULT_PAGE 2'h0
`define CTRL_PAGE 2'h1
`define CONV_CTRL_ADDR 5'h00
`define DAC_CTRL_ADDR 5'h02
`define RESULT_COUNT 5'h0a

// converter and dac control field positions
`define PEN_MODE_BIT 15
`define BUSY_STOP_BIT 14
`define FUNC_HI 13
`define FUNC_LO 10
`define RES_HI 9
`define RES_LO 8
`define AVG_HI 7
`define AVG_LO 6
`define CCLK_HI 5
`define CCLK_LO 4
`define SETTLE_HI 3
`define SETTLE_LO 1
`define DAC_PD_BIT 15

// reset values
`define PEN_MODE_RST 1'b0
`define FUNC_RST 4'h0
`define RES_RST 2'h0
`define AVG_RST 2'h0
`define CCLK_RST 2'h0
`define SETTLE_RST 3'h0
`define DAC_PD_RST 1'b1

// result slots, also the converter channel numbers
`define CH_X 4'h0
`define CH_Y 4'h1
`define CH_P1 4'h2
`define CH_P2 4'h3
`define CH_BATTERY_ONE_RESULT 4'h4
`define CH_BATTERY_TWO_RESULT 4'h5
`define CH_AUX_ONE_RESULT 4'h6
`define CH_AUX_TWO_RESULT 4'h7
`define CH_TEMP1 4'h8
`define CH_TEMP2 4'h9

// timing
`define CLK_PERIOD_NS 40
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_T_8M_NS 125
`define CONV_T_4M_NS 250
`define CONV_T_2M_NS 500
`define CONV_T_1M_NS 1000
`define SETTLE_T1_US 100
`define SETTLE_T2_US 500
`define SETTLE_T3_US 1000
`define SETTLE_T4_US 5000
`define SETTLE_T5_US 10000
`define SETTLE_T6_US 50000
`define SETTLE_T7_US 100000

`endif

// ### verif/adc_model.sv
module adc_model
(
    input wire logic clk,
    input wire logic power,
    input wire logic [3:0] channel,
    input wire logic [11:0] base,
    output logic [11:0] sample
);
    timeunit 1ns;
    timeprecision 1ns;
    initial sample = 12'h5a5;
    // steady per channel so an average equals one sample; unpowered it toggles
    always @(posedge clk)
    begin
        if (power)
            sample <= base ^ {3{channel}};
        else
            sample <= ~sample;
    end
endmodule : adc_model

// ### verif/touch_adc_ctrl_checker.sv
module touch_adc_ctrl_checker
    import touch_adc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire reg_req_s REG_REQ,
    input wire logic [15:0] REG_RDATA,
    input wire logic ADC_POWER,
    input wire logic ADC_START,
    input wire panel_drive_s PANEL_DRIVE,
    input wire logic DATA_AVAILABLE_OUT_N,
    input wire logic DAC_POWER_DOWN
);
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    logic wc, rc, wd, rdc;
    logic [3:0] dx;
    // register hits, decoded once for all properties
    assign wc = REG_REQ.wr && REG_REQ.page == 2'h1 && REG_REQ.addr == 5'h00;
    assign rc = REG_REQ.rd && REG_REQ.page == 2'h1 && REG_REQ.addr == 5'h00;
    assign wd = REG_REQ.wr && REG_REQ.page == 2'h1 && REG_REQ.addr == 5'h02;
    assign rdc = REG_REQ.rd && REG_REQ.page == 2'h1 && REG_REQ.addr == 5'h02;
    // driver pair expected for codes 13..15
    assign dx = REG_REQ.wdata[11:10] == 2'h1 ? 4'hc : (REG_REQ.wdata[10] ? 4'h6 : 4'h3);

    chk_start_busy: assert property (ADC_START |-> ADC_POWER && DATA_AVAILABLE_OUT_N)
        else $error("start outside a busy sequence");
    chk_launch_power: assert property (wc && REG_REQ.wdata[15:14] == 2'h0 &&
        REG_REQ.wdata[13:10] inside {[4'h1:4'hc]} |=> ADC_POWER && DATA_AVAILABLE_OUT_N)
        else $error("conversion write did not power up");
    chk_func_zero: assert property (wc && REG_REQ.wdata[15:10] == 6'h00 |=>
        (!ADC_START && PANEL_DRIVE == 4'h0) [*4])
        else $error("invalid code started work");
    chk_drive_pair: assert property (wc && REG_REQ.wdata[15:12] == 4'h3 &&
        REG_REQ.wdata[11:10] != 2'h0 |=> PANEL_DRIVE == $past(dx))
        else $error("wrong driver pair");
    chk_stop_halt: assert property (wc && REG_REQ.wdata[14] |=> (!ADC_POWER && !ADC_START) [*3])
        else $error("stop did not halt");
    chk_bit0_zero: assert property (rc |-> ##2 !REG_RDATA[0])
        else $error("reserved bit read as one");
    chk_dac_write: assert property (wd |=> DAC_POWER_DOWN == $past(REG_REQ.wdata[15]))
        else $error("dac power bit not updated");
    chk_dac_read: assert property (rdc |-> ##2 REG_RDATA == {DAC_POWER_DOWN, 15'h0})
        else $error("dac register read wrong");
    chk_reset_vals: assert property ($rose(RESET_N) |-> DAC_POWER_DOWN &&
        DATA_AVAILABLE_OUT_N && !ADC_POWER && PANEL_DRIVE == 4'h0)
        else $error("wrong values after reset");
endmodule : touch_adc_ctrl_checker

bind touch_adc_ctrl touch_adc_ctrl_checker i_chk (.CORE_CLK, .RESET_N, .REG_REQ, .REG_RDATA,
    .ADC_POWER, .ADC_START, .PANEL_DRIVE, .DATA_AVAILABLE_OUT_N, .DAC_POWER_DOWN);

// ### verif/touch_adc_function_control_bench.sv
module touch_adc_function_control_bench
    import touch_adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, pen = 0, pwr, start, dav_n, dacpd;
    reg_req_s req = '0;
    logic [15:0] rdata;
    logic [3:0] ch;
    logic [11:0] samp, base = 12'h0;
    panel_drive_s drv;
    int error_cnt = 0, checked = 0, starts = 0, cyc = 0;
    int exp_r[10] = '{default: -1};
    logic [31:0] lf = 32'd96528;

    // the longest settle keeps its full default, so panel scans never pick it
    touch_adc_ctrl #(.SETTLE_CYC_2(20), .SETTLE_CYC_3(30), .SETTLE_CYC_4(40),
        .SETTLE_CYC_5(50), .SETTLE_CYC_6(60)) i_dut (
        .CORE_CLK(clk), .RESET_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
        .PEN_DOWN(pen), .ADC_POWER(pwr), .ADC_START(start), .ADC_CHANNEL(ch),
        .ADC_SAMPLE(samp), .PANEL_DRIVE(drv), .DATA_AVAILABLE_OUT_N(dav_n),
        .DAC_POWER_DOWN(dacpd));
    adc_model i_adc (.clk(clk), .power(pwr), .channel(ch), .base(base), .sample(samp));

    initial
    begin
        forever #20 clk = ~clk;
    end

    // start pulses counted here; the ceiling cuts a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (start === 1'b1)
            starts++;
        if (cyc == 90000)
        begin
            error_cnt++;
            test_done();
        end
    end

    function logic [31:0] nxt(logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
    endfunction : nxt

    // channel list per function, low nibble first, f ends it
    function logic [15:0] tbl(int f);
        case (f)
            1: return 16'hff10;
            2: return 16'h3210;
            3: return 16'hfff0;
            4: return 16'hfff1;
            5: return 16'hff32;
            10: return 16'hfff8;
            11: return 16'h7654;
            12: return 16'hfff9;
            default: return {12'hfff, 4'(f - 2)};
        endcase
    endfunction : tbl

    task cmp(string n, logic [15:0] e, logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask : cmp

    // one register access; data taken once the answer has settled
    task bus(logic w, logic [1:0] p, logic [4:0] a, logic [15:0] d, output logic [15:0] q);
        req = '{w, !w, p, a, d};
        @(negedge clk);
        req = '0;
        @(negedge clk);
        q = rdata;
    endtask : bus

    task rcmp(string n, logic [1:0] p, logic [4:0] a, logic [15:0] e);
        logic [15:0] q;
        bus(1'b0, p, a, 16'h0, q);
        cmp(n, e, q);
    endtask : rcmp

    task test_done();
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    initial
    begin
        logic [15:0] q, w, tb;
        int f, r, av, ck, sv, n, c;
        repeat (10) @(negedge clk);
        rst_n = 1;
        rcmp("ctrl", 2'h1, 5'h00, 16'h4000);
        rcmp("dac", 2'h1, 5'h02, 16'h8000);
        bus(1'b1, 2'h1, 5'h02, 16'h0000, q);
        rcmp("dac", 2'h1, 5'h02, 16'h0000);
        rcmp("unmapped", 2'h1, 5'h05, 16'h0000);
        for (f = 1; f < 16; f++)
        begin
            lf = nxt(lf);
            r = lf[1:0];
            av = lf[3:2];
            ck = lf[5:4];
            sv = lf[8:6];
            // slow clock with deep averaging, or long settles, would blow the budget
            if (ck == 3)
                av = lf[2];
            if (f < 6 && (sv == 1 || sv == 7))
                sv = 6;
            // fast clocks only with low resolution
            if (ck == 0)
                r = 1;
            if (ck == 1 && r != 1)
                r = 2;
            base = lf[31:20];
            w = {2'b00, 4'(f), 2'(r), 2'(av), 2'(ck), 3'(sv), 1'b0};
            starts = 0;
            bus(1'b1, 2'h1, 5'h00, w, q);
            if (f > 12)
                cmp("drive", {12'h0, f == 13 ? 4'hc : (f == 14 ? 4'h3 : 4'h6)}, {12'h0, drv});
            else
            begin
                n = 0;
                while (dav_n !== 1'b0 && n < 60000)
                begin
                    @(negedge clk);
                    n++;
                end
                tb = tbl(f);
                n = 0;
                for (int i = 0; i < 4 && tb[4 * i +: 4] != 4'hf; i++)
                begin
                    c = tb[4 * i +: 4];
                    exp_r[c] = int'(base ^ {3{4'(c)}}) >> (r == 1 ? 4 : (r == 2 ? 2 : 0));
                    n++;
                end
                cmp("starts", 16'(n * (av != 0 ? 2 << av : 1)), 16'(starts));
                for (c = 0; c < 10; c++)
                    if (exp_r[c] >= 0)
                        rcmp("result", 2'h0, 5'(c), 16'(exp_r[c]));
                rcmp("ctrl", 2'h1, 5'h00, w | 16'h4000);
            end
        end
        bus(1'b1, 2'h1, 5'h00, 16'h0000, q);
        cmp("drive", 16'h0, {12'h0, drv});
        // touch-driven scan, then a stop with the pen still down
        pen = 1;
        starts = 0;
        bus(1'b1, 2'h1, 5'h00, 16'h8420, q);
        repeat (300) @(negedge clk);
        cmp("pen scan", 16'h1, {15'h0, starts > 0});
        bus(1'b1, 2'h1, 5'h00, 16'h4000, q);
        n = starts;
        repeat (300) @(negedge clk);
        cmp("stop", 16'(n), 16'(starts));
        cmp("power", 16'h0, {15'h0, pwr});
        rcmp("ctrl", 2'h1, 5'h00, 16'hc000);
        pen = 0;
        test_done();
    end
endmodule : touch_adc_function_control_bench
